/* File: verilog/pcgrs_consts.svh */
// constants for the peripheral clock gate and reset source block
`ifndef PCGRS_CONSTS_SVH
`define PCGRS_CONSTS_SVH
`define PCGRS_ADDR_GATE    32'hE01FC0C4
`define PCGRS_ADDR_CAUSE   32'hE01FC180
`define PCGRS_BIT_TIMER0   1
`define PCGRS_BIT_TIMER1   2
`define PCGRS_BIT_SERIAL0  3
`define PCGRS_BIT_SERIAL1  4
`define PCGRS_BIT_PWM      5
`define PCGRS_BIT_TWOWIRE0 7
`define PCGRS_BIT_SPI      8
`define PCGRS_BIT_CALENDAR 9
`define PCGRS_BIT_SYNCSER  10
`define PCGRS_BIT_CONV0    12
`define PCGRS_BIT_TWOWIRE1 19
`define PCGRS_BIT_CONV1    20
`define PCGRS_GATE_MASK ((32'h1 << `PCGRS_BIT_TIMER0) | (32'h1 << `PCGRS_BIT_TIMER1) | \
	(32'h1 << `PCGRS_BIT_SERIAL0) | (32'h1 << `PCGRS_BIT_SERIAL1) | (32'h1 << `PCGRS_BIT_PWM) | \
	(32'h1 << `PCGRS_BIT_TWOWIRE0) | (32'h1 << `PCGRS_BIT_SPI) | (32'h1 << `PCGRS_BIT_CALENDAR) | \
	(32'h1 << `PCGRS_BIT_SYNCSER) | (32'h1 << `PCGRS_BIT_CONV0) | (32'h1 << `PCGRS_BIT_TWOWIRE1) | \
	(32'h1 << `PCGRS_BIT_CONV1))
`define PCGRS_GATE_RST     (`PCGRS_GATE_MASK & ~(32'h1 << `PCGRS_BIT_CONV1))
`define PCGRS_CAUSE_POR    0
`define PCGRS_CAUSE_PIN    1
`define PCGRS_CAUSE_WDT    2
`define PCGRS_CAUSE_BROWN  3
`define PCGRS_CAUSE_RST    4'h1
`define PCGRS_CLK_NS       100
`define PCGRS_FILT_NS      300
`define PCGRS_FILT_CYC     ((`PCGRS_FILT_NS + `PCGRS_CLK_NS - 1) / `PCGRS_CLK_NS)
`define PCGRS_WAKE_CYC     4096
`define PCGRS_INIT_CYC     8
`define PCGRS_BOOT_ADDR    32'h00000000
`define PCGRS_RESP_OKAY    2'h0
`define PCGRS_RESP_SLVERR  2'h2
`endif

/* File: verilog/pcgrs_pkg.sv */
// types for the peripheral clock gate and reset source block
`default_nettype none
package pcgrs_pkg;
	typedef enum logic [2:0] {ST_HOLD, ST_WAKE, ST_INIT, ST_FLASH, ST_RUN} pcgrs_state_t;
	typedef enum logic [1:0] {SEL_NONE, SEL_GATE, SEL_CAUSE} pcgrs_sel_t;
	typedef struct packed {
		logic pin_reset_n;
		logic osc_running;
		logic wdt_reset;
		logic brownout_reset;
		logic flash_busy;
	} pcgrs_src_t;
endpackage
`default_nettype wire

/* File: verilog/pcgrs_top.sv */
// peripheral clock gating and reset source sequencing with an axi4-lite register slave
// How it works
// - gate bit one runs that peripheral clock
// - fixed gate bit per peripheral
// - all gates on after reset, converter1 off
// - peripheral access valid only while gated on
// - always-on blocks have no gate bit
// - pin, watchdog and brown-out reset sources
// - reset held until pin, oscillator, count, init
// - short pin reset pulses are filtered out
// - processor starts at address zero
// - config pins latched only by pin reset
// - busy flash delays reset release
// - reset cause bits are write-one-to-clear
// - power-on sets bit0, clears the others
// - pin reset sets bit1, power-on clears
// - watchdog sets bit2, other sources clear
// - brown-out sets bit3
// - wake timer counts 4096 oscillator clocks
`timescale 1ns/100ps
`default_nettype none
`include "pcgrs_consts.svh"
module pcgrs_top
	import pcgrs_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire pcgrs_src_t  src,
	input  wire logic [1:0]  cfg_pins,
	output logic [1:0]       cfg_latched,
	output logic             sys_rst_n,
	output logic [31:0]      boot_addr,
	output logic [31:0]      periph_en,
	output logic [31:0]      periph_clk,
	output logic             free_clk,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	localparam logic [31:0] GMASK = `PCGRS_GATE_MASK;
	localparam logic [31:0] GRST = `PCGRS_GATE_RST;
	localparam logic [1:0] FILT = 2'(`PCGRS_FILT_CYC);
	localparam logic [12:0] WAKE = 13'(`PCGRS_WAKE_CYC);
	localparam logic [12:0] INIT = 13'(`PCGRS_INIT_CYC);

	function automatic pcgrs_sel_t decode(input logic [31:0] a);
		if (a == `PCGRS_ADDR_GATE)
			decode = SEL_GATE;
		else if (a == `PCGRS_ADDR_CAUSE)
			decode = SEL_CAUSE;
		else
			decode = SEL_NONE;
	endfunction

	pcgrs_state_t state_q;
	pcgrs_state_t state_d;
	logic [12:0]  cnt_q;
	logic [12:0]  cnt_d;
	logic [1:0]   filt_q;
	logic         pin_f_q;
	logic         sys_rst_n_q;
	logic [1:0]   cfg_q;
	logic [31:0]  gate_q;
	logic [31:0]  gate_d;
	logic [31:0]  gate_lo_q;
	logic [3:0]   cause_q;
	logic [3:0]   cause_d;
	logic         aw_hold_q;
	logic [31:0]  awaddr_q;
	logic         w_hold_q;
	logic [31:0]  wdata_q;
	logic [3:0]   wstrb_q;
	logic         bvalid_q;
	logic [1:0]   bresp_q;
	logic         rvalid_q;
	logic [31:0]  rdata_q;
	logic [1:0]   rresp_q;

	// reset sources and sequencing
	wire        pin_low = !src.pin_reset_n;
	wire        any_src = pin_f_q | src.wdt_reset | src.brownout_reset;
	wire        wake_done = (cnt_q == WAKE - 13'h1);
	wire        init_done = (cnt_q == INIT - 13'h1);
	wire [1:0]  filt_nx = (filt_q == FILT) ? filt_q : filt_q + 2'h1;

	// pin reset filter: counts consecutive low samples, a shorter pulse never reaches the sequencer
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			filt_q <= 2'h0;
			pin_f_q <= 1'b0;
		end else begin
			filt_q <= pin_low ? filt_nx : 2'h0;
			pin_f_q <= pin_low && (filt_nx == FILT);
		end
	end

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			ST_HOLD: begin
				cnt_d = 13'h0;
				if (!any_src && src.osc_running)
					state_d = ST_WAKE;
			end
			ST_WAKE: begin
				cnt_d = cnt_q + 13'h1;
				if (!src.osc_running) begin
					state_d = ST_HOLD;
				end else if (wake_done) begin
					state_d = ST_INIT;
					cnt_d = 13'h0;
				end
			end
			ST_INIT: begin
				cnt_d = cnt_q + 13'h1;
				if (init_done)
					state_d = ST_FLASH;
			end
			ST_FLASH: begin
				// aborted flash work must settle before the core runs
				if (!src.flash_busy)
					state_d = ST_RUN;
			end
			default: begin
				cnt_d = 13'h0;
			end
		endcase
		if (any_src) begin
			state_d = ST_HOLD;
			cnt_d = 13'h0;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_HOLD;
			cnt_q <= 13'h0;
			sys_rst_n_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			sys_rst_n_q <= (state_d == ST_RUN);
		end
	end

	// strap latch: only the filtered pin reset reloads it
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			cfg_q <= 2'h0;
		else if (pin_f_q)
			cfg_q <= cfg_pins;
	end

	// register bus
	wire        wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
	wire        ar_fire = s_axi_arvalid && !rvalid_q;
	pcgrs_sel_t wsel;
	pcgrs_sel_t rsel;
	assign wsel = decode(awaddr_q);
	assign rsel = decode(s_axi_araddr);
	wire        wr_gate = wr_fire && (wsel == SEL_GATE);
	wire        wr_cause = wr_fire && (wsel == SEL_CAUSE);
	wire [31:0] strb_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire [31:0] rd_mux = (rsel == SEL_GATE) ? gate_q :
		(rsel == SEL_CAUSE) ? {28'h0, cause_q} : 32'h0;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			aw_hold_q <= 1'b0;
			awaddr_q <= 32'h0;
			w_hold_q <= 1'b0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_hold_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_hold_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			bvalid_q <= 1'b0;
			bresp_q <= `PCGRS_RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= `PCGRS_RESP_OKAY;
		end else begin
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= (wsel == SEL_NONE) ? `PCGRS_RESP_SLVERR : `PCGRS_RESP_OKAY;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (ar_fire) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_mux;
				rresp_q <= (rsel == SEL_NONE) ? `PCGRS_RESP_SLVERR : `PCGRS_RESP_OKAY;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// gate register: reserved bits never store, so they read back zero
	always_comb begin
		gate_d = gate_q;
		if (wr_gate)
			gate_d = ((gate_q & ~strb_mask) | (wdata_q & strb_mask)) & GMASK;
		if (!sys_rst_n_q)
			gate_d = GRST;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			gate_q <= GRST;
		else
			gate_q <= gate_d;
	end

	// reset cause: a source set wins over a same-cycle software clear
	wire [3:0] clr_w = (wr_cause && wstrb_q[0]) ? wdata_q[3:0] : 4'h0;
	wire       wdt_lost = (pin_f_q || src.brownout_reset) && !src.wdt_reset;

	always_comb begin
		cause_d[`PCGRS_CAUSE_POR] = cause_q[`PCGRS_CAUSE_POR] && !clr_w[`PCGRS_CAUSE_POR];
		cause_d[`PCGRS_CAUSE_PIN] = pin_f_q || (cause_q[`PCGRS_CAUSE_PIN] && !clr_w[`PCGRS_CAUSE_PIN]);
		cause_d[`PCGRS_CAUSE_WDT] = src.wdt_reset ||
			(cause_q[`PCGRS_CAUSE_WDT] && !clr_w[`PCGRS_CAUSE_WDT] && !wdt_lost);
		cause_d[`PCGRS_CAUSE_BROWN] = src.brownout_reset ||
			(cause_q[`PCGRS_CAUSE_BROWN] && !clr_w[`PCGRS_CAUSE_BROWN]);
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			cause_q <= `PCGRS_CAUSE_RST;
		else
			cause_q <= cause_d;
	end

	// enables move on the falling edge, while the clock is low, so no pulse is cut short
	always_ff @(negedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			gate_lo_q <= GRST;
		else
			gate_lo_q <= gate_q;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : g_clk
			if (GMASK[gi]) begin : g_on
				assign periph_clk[gi] = clk_sys & gate_lo_q[gi];
			end else begin : g_off
				assign periph_clk[gi] = 1'b0;
			end
		end
	endgenerate

	assign free_clk = clk_sys;
	assign periph_en = gate_q;
	assign sys_rst_n = sys_rst_n_q;
	assign boot_addr = `PCGRS_BOOT_ADDR;
	assign cfg_latched = cfg_q;
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready = !w_hold_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	chk_source_holds: assert property (any_src |=> !sys_rst_n_q)
		else $error("reset released while a source is active");
	chk_filter_min: assert property ($rose(pin_f_q) |-> $past(pin_low, 1) && $past(pin_low, 2)
		&& $past(pin_low, 3))
		else $error("pin reset accepted shorter than filter");
	chk_wake_osc: assert property (state_q == ST_WAKE && !src.osc_running && !any_src |=> state_q == ST_HOLD)
		else $error("wake count ran without oscillator");
	chk_flash_hold: assert property (state_q == ST_FLASH && src.flash_busy |=> !sys_rst_n_q)
		else $error("reset released during flash busy");
	chk_gate_reset: assert property (!sys_rst_n_q |=> gate_q == GRST)
		else $error("gate register not at reset value");
	chk_cfg_keep: assert property (!pin_f_q |=> $stable(cfg_q))
		else $error("strap latch changed without pin reset");
	chk_por_bit: assert property (!$rose(cause_q[`PCGRS_CAUSE_POR]))
		else $error("power-on bit set by another source");
	chk_pin_sets: assert property (pin_f_q |=> cause_q[`PCGRS_CAUSE_PIN])
		else $error("pin reset bit not set");
	chk_wdt_bit: assert property (src.wdt_reset |=> cause_q[`PCGRS_CAUSE_WDT])
		else $error("watchdog bit not set");
	chk_brownout_bit: assert property (src.brownout_reset |=> cause_q[`PCGRS_CAUSE_BROWN])
		else $error("brown-out bit not set");
	chk_cause_w1c: assert property (wr_cause && wstrb_q[0] && wdata_q[3] && !src.brownout_reset
		|=> !cause_q[`PCGRS_CAUSE_BROWN])
		else $error("write one did not clear cause bit");
	chk_gate_rsvd: assert property (wr_gate && sys_rst_n_q |=> (gate_q & ~GMASK) == 32'h0)
		else $error("reserved gate bit stored");

	cov_release: cover property ($rose(sys_rst_n_q));
	cov_wdt_reset: cover property (src.wdt_reset ##1 !sys_rst_n_q);
	cov_gate_write: cover property (wr_gate ##1 s_axi_bvalid && s_axi_bready);

endmodule // pcgrs_top
`default_nettype wire

/* File: test/pcgrs_top_tb.sv */
// self-checking bench for the clock gate and reset source block
`timescale 1ns/100ps
`default_nettype none
`include "pcgrs_consts.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end
module pcgrs_top_tb
	import pcgrs_pkg::*;
;
	localparam logic [31:0] GA = `PCGRS_ADDR_GATE;
	localparam logic [31:0] CA = `PCGRS_ADDR_CAUSE;
	logic        clk_sys, reset_n;
	pcgrs_src_t  src;
	logic [1:0]  cfg_pins, cfg_latched, bresp, rresp, r, c;
	logic        sys_rst_n, free_clk;
	logic [31:0] boot_addr, periph_en, periph_clk, awaddr, wdata, araddr, rdata, d, gate_m, seed;
	logic [3:0]  wstrb, s;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	int          miscompares, total_checks, i, b;
	pcgrs_top u_pcgrs_top (.clk_sys(clk_sys), .reset_n(reset_n), .src(src), .cfg_pins(cfg_pins),
		.cfg_latched(cfg_latched), .sys_rst_n(sys_rst_n), .boot_addr(boot_addr), .periph_en(periph_en),
		.periph_clk(periph_clk), .free_clk(free_clk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic timeout();
		miscompares++;
		$display("unexpected wait expected end seen none");
		print_verdict();
	endtask
	// ready is sampled at the falling edge, where it already equals its value at the next rising edge
	task automatic wr(input logic [31:0] a, input logic [31:0] dv, input logic [3:0] sv, output logic [1:0] rv);
		int n;
		logic ta, tw, tb;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= dv;
		wstrb <= sv;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		tb = 1'b0;
		for (n = 0; n < 50 && !tb; n++) begin
			@(negedge clk_sys);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			rv = bresp;
			@(posedge clk_sys);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end
		if (!tb) timeout();
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] dv, output logic [1:0] rv);
		int n;
		logic ta, tb;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		tb = 1'b0;
		for (n = 0; n < 50 && !tb; n++) begin
			@(negedge clk_sys);
			ta = arvalid && arready;
			tb = rvalid;
			dv = rdata;
			rv = rresp;
			@(posedge clk_sys);
			if (ta) arvalid <= 1'b0;
			if (tb) rready <= 1'b0;
		end
		if (!tb) timeout();
	endtask
	task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input string nm);
		logic [31:0] dv;
		logic [1:0]  rv;
		rd(a, dv, rv);
		`CHK(nm, e, dv)
		`CHK("rresp", 2'h0, rv)
	endtask
	task automatic wait_rst(input logic v);
		int n;
		for (n = 0; n < 6000 && sys_rst_n !== v; n++)
			@(negedge clk_sys);
		if (sys_rst_n !== v) timeout();
	endtask
	// flips source bits for n cycles; pin is active low so a flip asserts it too
	task automatic pulse(input logic [4:0] m, input int n);
		@(posedge clk_sys);
		src <= src ^ m;
		repeat (n) @(posedge clk_sys);
		src <= src ^ m;
		@(negedge clk_sys);
	endtask
	initial begin
		reset_n = 1'b0;
		src = 5'b10000;
		cfg_pins = 2'h0;
		{awaddr, wdata, araddr, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		miscompares = 0;
		total_checks = 0;
		seed = 32'h0000004D;
		gate_m = 32'h000817BE;
		repeat (20) @(posedge clk_sys);
		`CHK("gate reset", 32'h000817BE, periph_en)
		reset_n <= 1'b1;
		repeat (100) @(posedge clk_sys);
		`CHK("no osc hold", 1'b0, sys_rst_n)
		src.osc_running <= 1'b1;
		wait_rst(1'b1);
		`CHK("boot", 32'h00000000, boot_addr)
		rdchk(GA, gate_m, "gate");
		rdchk(CA, 32'h1, "cause");
		wr(CA, 32'hF, 4'hF, r);
		rdchk(CA, 32'h0, "cause");
		$display("test reset done");
		for (i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			d = seed & 32'h001817BE;
			s = (i == 0) ? 4'hF : seed[31:28];
			wr(GA, d, s, r);
			`CHK("bresp", 2'h0, r)
			for (b = 0; b < 4; b++)
				if (s[b]) gate_m[8*b+:8] = d[8*b+:8];
			rdchk(GA, gate_m, "gate");
			`CHK("enable", gate_m, periph_en)
			@(posedge clk_sys);
			#25;
			`CHK("clk high", gate_m, periph_clk)
			`CHK("free clk", 1'b1, free_clk)
			#50;
			`CHK("clk low", 32'h0, periph_clk)
		end
		wr(32'hE01FC100, 32'hF, 4'hF, r);
		`CHK("bad bresp", 2'h2, r)
		rd(32'hE01FC100, d, r);
		`CHK("bad rresp", 2'h2, r)
		`CHK("bad rdata", 32'h0, d)
		$display("test gate done");
		pulse(5'b10000, 2);
		repeat (10) @(posedge clk_sys);
		`CHK("short pin", 1'b1, sys_rst_n)
		rdchk(CA, 32'h0, "cause");
		seed = lfsr(seed);
		c = seed[1:0];
		cfg_pins <= c;
		pulse(5'b10000, 6);
		`CHK("pin rst", 1'b0, sys_rst_n)
		`CHK("cfg", c, cfg_latched)
		repeat (100) @(posedge clk_sys);
		src.osc_running <= 1'b0;
		repeat (3) @(posedge clk_sys);
		`CHK("osc drop", 1'b0, sys_rst_n)
		src.osc_running <= 1'b1;
		repeat (4050) @(posedge clk_sys);
		`CHK("wake restart", 1'b0, sys_rst_n)
		wait_rst(1'b1);
		rdchk(CA, 32'h2, "cause");
		rdchk(GA, 32'h000817BE, "gate");
		wr(CA, 32'h0, 4'hF, r);
		rdchk(CA, 32'h2, "cause");
		$display("test pin done");
		cfg_pins <= ~c;
		pulse(5'b00100, 4);
		`CHK("wdt rst", 1'b0, sys_rst_n)
		`CHK("cfg kept", c, cfg_latched)
		wait_rst(1'b1);
		rdchk(CA, 32'h6, "cause");
		src.flash_busy <= 1'b1;
		pulse(5'b00010, 4);
		repeat (4300) @(posedge clk_sys);
		`CHK("flash hold", 1'b0, sys_rst_n)
		src.flash_busy <= 1'b0;
		wait_rst(1'b1);
		rdchk(CA, 32'hA, "cause");
		$display("test internal done");
		print_verdict();
	end
endmodule // pcgrs_top_tb
`default_nettype wire
